/* inc/sffe_pkg.sv */
// Function
// - io level governs virtual interrupt handling
// - nested task flag bit 14, read by return
// - task switch with nest request sets nested flag
// - legacy return with nested flag switches task
// - resume flag bit 16 suppresses repeat breakpoint
// - resume flag clears on retire, sometimes deferred
// - stacked image resume one, breakpoint gives zero
// - reloaded resume flag held until instruction completes
// - emulation mode bit 17, pop leaves it
// - alignment check bit 18 faults at level 3
// - virtual flag bit 19 active below level 3
// - active virtual flag takes interrupt enable changes
// - long mode honours virtual flags only with pvi
// - virtual pending bit 20, software written
// - enable while pending raises protection fault
// - probe bit 21 writable when query exists
// - feature register at index c0000080, privileged
// - bits 63:16, 9 zero; 7:1 read zero
// - feature control bit positions fixed
// - interrupt enable bit 9 gates maskable interrupts
// - io level bits 13:12 gate io instructions
package sffe_pkg;
  // ==========================================
  // flags register layout
  localparam int SFFE_CF_BIT     = 0;
  localparam int SFFE_ONE_BIT    = 1;
  localparam int SFFE_IE_BIT     = 9;
  localparam int SFFE_IO_PRIVILEGE_LEVEL_LO    = 12;
  localparam int SFFE_IO_PRIVILEGE_LEVEL_HI    = 13;
  localparam int SFFE_NT_BIT     = 14;
  localparam int SFFE_RF_BIT     = 16;
  localparam int SFFE_VM_BIT     = 17;
  localparam int SFFE_AC_BIT     = 18;
  localparam int SFFE_VIF_BIT    = 19;
  localparam int SFFE_VIP_BIT    = 20;
  localparam int SFFE_ID_BIT     = 21;
  localparam int SFFE_FLAGS_W    = 22;
  // writable bits, reserved 15, 5, 3, 1 excluded
  localparam logic [21:0] SFFE_FLAGS_WMASK = 22'h3f7fd5;
  localparam logic [21:0] SFFE_FLAGS_RST   = 22'h000002;
  localparam logic [1:0]  SFFE_USER_LEVEL  = 2'h3;
  // ==========================================
  // extended feature enable register
  localparam logic [31:0] SFFE_EXTENDED_FEATURE_ENABLE_INDEX = 32'hc000_0080;
  localparam int SFFE_SCE_BIT   = 0;
  localparam int SFFE_LME_BIT   = 8;
  localparam int SFFE_MBZ9_BIT  = 9;
  localparam int SFFE_LMA_BIT   = 10;
  localparam int SFFE_NXE_BIT   = 11;
  localparam int SFFE_SECURE_VIRTUALIZATION_ENABLE_BIT  = 12;
  localparam int SFFE_LONG_SEGMENT_LIMIT_ENABLE_BIT = 13;
  localparam int SFFE_FAST_STATE_SAVE_BIT = 14;
  localparam int SFFE_TCE_BIT   = 15;
  localparam logic [63:0] SFFE_EXTENDED_FEATURE_ENABLE_MBZ  = 64'hffff_ffff_ffff_0200;
  localparam logic [63:0] SFFE_EXTENDED_FEATURE_ENABLE_RWM  = 64'h0000_0000_0000_fd01;
  localparam logic [63:0] SFFE_EXTENDED_FEATURE_ENABLE_RST  = 64'h0000_0000_0000_0000;
endpackage

/* inc/sffe_msr_if.sv */
// ==========================================
// model register access between core and feature register
interface sffe_msr_if;
  logic        wr;
  logic        rd;
  logic [31:0] index;
  logic [63:0] wdata;
  logic [1:0]  current_privilege_level;
  logic        paging;
  logic [63:0] rdata;
  logic        done;
  logic        gp;
  logic [63:0] extended_feature_enable;
  modport core (output wr, rd, index, wdata, current_privilege_level, paging,
                input rdata, done, gp, extended_feature_enable);
  modport regs (input wr, rd, index, wdata, current_privilege_level, paging,
                output rdata, done, gp, extended_feature_enable);
endinterface

/* verilog/sffe_extended_feature_enable.sv */
module sffe_extended_feature_enable (
  // clock and reset
  input  wire logic   clk_in,
  input  wire logic   rst_n_in,
  input  wire logic   ce_in,
  // access port
  sffe_msr_if.regs    msr
);
  logic [63:0] extended_feature_enable_r;
  logic [63:0] wr_val;
  logic        hit;
  logic        priv_ok;
  logic        bad_wr;
  logic        lma_hw;

  // ==========================================
  // decode
  assign hit     = msr.index == sffe_pkg::SFFE_EXTENDED_FEATURE_ENABLE_INDEX;
  assign priv_ok = msr.current_privilege_level == 2'h0;
  assign lma_hw  = extended_feature_enable_r[sffe_pkg::SFFE_LME_BIT] & msr.paging;
  assign wr_val  = msr.wdata & sffe_pkg::SFFE_EXTENDED_FEATURE_ENABLE_RWM;
  // reserved ones, privilege or a forged active bit all refuse
  assign bad_wr  = (|(msr.wdata & sffe_pkg::SFFE_EXTENDED_FEATURE_ENABLE_MBZ))
                 | !priv_ok
                 | (msr.wdata[sffe_pkg::SFFE_LMA_BIT] != lma_hw);

  // register contents; active bit always follows hardware
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      extended_feature_enable_r <= sffe_pkg::SFFE_EXTENDED_FEATURE_ENABLE_RST;
    end else if (ce_in) begin
      if (msr.wr && hit && !bad_wr) begin
        extended_feature_enable_r <= wr_val;
      end else begin
        extended_feature_enable_r[sffe_pkg::SFFE_LMA_BIT] <= lma_hw;
      end
    end
  end

  // answer: data, done and fault one cycle after the request
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      msr.rdata <= 64'h0;
      msr.done  <= 1'b0;
      msr.gp    <= 1'b0;
    end else if (ce_in) begin
      msr.done  <= hit & (msr.wr | msr.rd);
      msr.gp    <= hit & ((msr.wr & bad_wr) | (msr.rd & !priv_ok));
      if (hit && msr.rd && priv_ok) begin
        msr.rdata <= extended_feature_enable_r & sffe_pkg::SFFE_EXTENDED_FEATURE_ENABLE_RWM;
      end
    end
  end

  assign msr.extended_feature_enable = extended_feature_enable_r;
endmodule

/* verilog/sffe_top.sv */
module sffe_top #(
  parameter bit FEAT_QUERY_IMPL = 1'b1
) (
  // clock, reset, enable
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  // mode and privilege
  input  wire logic [1:0]  cpl_in,
  input  wire logic        emu_ext_in,
  input  wire logic        prot_vint_in,
  input  wire logic        align_mask_in,
  input  wire logic        paging_in,
  // model register access
  input  wire logic        msr_wr_in,
  input  wire logic        msr_rd_in,
  input  wire logic [31:0] msr_index_in,
  input  wire logic [63:0] msr_wdata_in,
  output logic [63:0]      msr_rdata_out,
  output logic             msr_done_out,
  output logic             msr_gp_out,
  output logic [63:0]      extended_feature_enable_out,
  // flags writes and events
  input  wire logic        flags_wr_in,
  input  wire logic [63:0] flags_wdata_in,
  input  wire logic        retire_in,
  input  wire logic        task_sw_in,
  input  wire logic        task_sw_nest_in,
  input  wire logic        task_sw_gate_in,
  input  wire logic [63:0] task_sw_flags_in,
  input  wire logic        interrupt_return_in,
  input  wire logic [63:0] interrupt_return_flags_in,
  input  wire logic        exc_in,
  input  wire logic        exc_ibp_in,
  input  wire logic        int_en_set_in,
  input  wire logic        int_en_clr_in,
  input  wire logic        io_instr_in,
  input  wire logic        mem_unaligned_in,
  input  wire logic        ibp_hit_in,
  // flag state and decisions
  output logic [63:0]      flags_out,
  output logic [63:0]      stacked_flags_out,
  output logic             int_admit_out,
  output logic             vif_active_out,
  output logic             interrupt_return_task_sw_out,
  output logic             ibp_db_out,
  output logic             gp_fault_out,
  output logic             ac_fault_out
);
  // ==========================================
  // reset release
  logic       rst_s1_r;
  logic       rst_s2_r;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  wire logic rst_n = rst_s2_r;

  // ==========================================
  // feature register
  sffe_msr_if msr_bus ();

  assign msr_bus.wr     = msr_wr_in;
  assign msr_bus.rd     = msr_rd_in;
  assign msr_bus.index  = msr_index_in;
  assign msr_bus.wdata  = msr_wdata_in;
  assign msr_bus.current_privilege_level    = cpl_in;
  assign msr_bus.paging = paging_in;

  sffe_extended_feature_enable u_extended_feature_enable (
    .clk_in   (mclk_in),
    .rst_n_in (rst_n),
    .ce_in    (ce_in),
    .msr      (msr_bus.regs)
  );

  assign msr_rdata_out = msr_bus.rdata;
  assign msr_done_out  = msr_bus.done;
  assign msr_gp_out    = msr_bus.gp;
  assign extended_feature_enable_out      = msr_bus.extended_feature_enable;

  // ==========================================
  // flag state
  logic [21:0] flags_r;
  logic [21:0] flags_nxt;
  logic        rf_r;
  logic        rf_hold_r;
  logic        rf_nxt;
  logic        rf_hold_nxt;
  logic        long_mode;
  logic [1:0]  io_privilege_level;
  logic        vif_act;
  logic        vint_gp;
  logic        io_gp;
  logic [21:0] wmask;
  logic [21:0] pop_mask;
  logic [21:0] img;

  assign long_mode = msr_bus.extended_feature_enable[sffe_pkg::SFFE_LMA_BIT];
  assign io_privilege_level      = flags_r[sffe_pkg::SFFE_IO_PRIVILEGE_LEVEL_HI:sffe_pkg::SFFE_IO_PRIVILEGE_LEVEL_LO];
  assign img       = {flags_r[21:17], rf_r, flags_r[15:0]};

  // probe bit only movable when the query instruction exists
  assign wmask = FEAT_QUERY_IMPL ? sffe_pkg::SFFE_FLAGS_WMASK
               : sffe_pkg::SFFE_FLAGS_WMASK
                 & ~(22'h1 << sffe_pkg::SFFE_ID_BIT);

  // pop may not touch emulation mode
  assign pop_mask = wmask & ~(22'h1 << sffe_pkg::SFFE_VM_BIT);

  // virtual interrupt mechanism: long mode only via pvi
  always_comb begin
    if (long_mode) begin
      vif_act = prot_vint_in;
    end else begin
      vif_act = emu_ext_in | prot_vint_in;
    end
    vif_act = vif_act && (io_privilege_level < sffe_pkg::SFFE_USER_LEVEL);
  end

  // enabling while a virtual interrupt pends is refused
  assign vint_gp = vif_act & int_en_set_in
                 & flags_r[sffe_pkg::SFFE_VIP_BIT];

  // io instruction at a weaker level than allowed
  assign io_gp = io_instr_in & (cpl_in > io_privilege_level);

  // next flags: task switch, then return, then pop, then sti/cli
  always_comb begin
    flags_nxt = flags_r;
    if (task_sw_in) begin
      flags_nxt = (task_sw_flags_in[21:0] & sffe_pkg::SFFE_FLAGS_WMASK)
                | sffe_pkg::SFFE_FLAGS_RST;
      if (!FEAT_QUERY_IMPL) begin
        flags_nxt[sffe_pkg::SFFE_ID_BIT] = 1'b0;
      end
      if (task_sw_nest_in) begin
        flags_nxt[sffe_pkg::SFFE_NT_BIT] = 1'b1;
      end
    end else if (interrupt_return_in) begin
      flags_nxt = (interrupt_return_flags_in[21:0] & wmask)
                | sffe_pkg::SFFE_FLAGS_RST;
    end else if (flags_wr_in) begin
      flags_nxt = (flags_r & ~pop_mask)
                | (flags_wdata_in[21:0] & pop_mask);
    end else if ((int_en_set_in || int_en_clr_in) && !vint_gp) begin
      if (vif_act) begin
        flags_nxt[sffe_pkg::SFFE_VIF_BIT] = int_en_set_in;
      end else begin
        flags_nxt[sffe_pkg::SFFE_IE_BIT] = int_en_set_in;
      end
    end
    flags_nxt[sffe_pkg::SFFE_RF_BIT] = 1'b0;
  end

  // architectural flag bits other than resume
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= sffe_pkg::SFFE_FLAGS_RST;
    end else if (ce_in) begin
      flags_r <= flags_nxt;
    end
  end

  // ==========================================
  // resume flag; cleared at retirement or written by a flags load, not by a fault, so a faulting
  // instruction restarts with it still set
  // same priority as the other flag bits, so the image agrees
  always_comb begin
    rf_nxt      = rf_r;
    rf_hold_nxt = rf_hold_r;
    if (task_sw_in) begin
      rf_nxt      = task_sw_flags_in[sffe_pkg::SFFE_RF_BIT];
      rf_hold_nxt = task_sw_gate_in;
    end else if (interrupt_return_in) begin
      rf_nxt      = interrupt_return_flags_in[sffe_pkg::SFFE_RF_BIT];
      rf_hold_nxt = interrupt_return_flags_in[sffe_pkg::SFFE_RF_BIT];
    end else if (flags_wr_in) begin
      rf_nxt      = flags_wdata_in[sffe_pkg::SFFE_RF_BIT];
      rf_hold_nxt = 1'b0;
    end else if (retire_in) begin
      // deferred case spends its one extra instruction here
      if (rf_hold_r) begin
        rf_hold_nxt = 1'b0;
      end else begin
        rf_nxt = 1'b0;
      end
    end
  end

  // resume state registers
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rf_r      <= 1'b0;
      rf_hold_r <= 1'b0;
    end else if (ce_in) begin
      rf_r      <= rf_nxt;
      rf_hold_r <= rf_hold_nxt;
    end
  end

  // ==========================================
  // stacked image on exception entry
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      stacked_flags_out <= 64'h0;
    end else if (ce_in && exc_in) begin
      stacked_flags_out <= {42'h0, img};
      // breakpoint entry must not hide its own restart
      stacked_flags_out[sffe_pkg::SFFE_RF_BIT] <= !exc_ibp_in;
    end
  end

  // ==========================================
  // visible state
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      flags_out      <= 64'h2;
      int_admit_out  <= 1'b0;
      vif_active_out <= 1'b0;
    end else if (ce_in) begin
      flags_out      <= {42'h0, flags_nxt[21:17],
                         rf_nxt, flags_nxt[15:0]};
      int_admit_out  <= flags_nxt[sffe_pkg::SFFE_IE_BIT];
      vif_active_out <= vif_act;
    end
  end

  // ==========================================
  // decision pulses, one cycle after the cause
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_return_task_sw_out <= 1'b0;
      ibp_db_out       <= 1'b0;
      gp_fault_out     <= 1'b0;
      ac_fault_out     <= 1'b0;
    end else if (ce_in) begin
      // legacy return out of a nested task switches back
      interrupt_return_task_sw_out <= interrupt_return_in & !long_mode
                        & flags_r[sffe_pkg::SFFE_NT_BIT];
      ibp_db_out       <= ibp_hit_in & !rf_r;
      gp_fault_out     <= vint_gp | io_gp;
      ac_fault_out     <= mem_unaligned_in & align_mask_in
                        & flags_r[sffe_pkg::SFFE_AC_BIT]
                        & (cpl_in == sffe_pkg::SFFE_USER_LEVEL);
    end
  end
endmodule

/* bench/sffe_props.sv */
module sffe_props (
  // clock, reset, privilege
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  input wire logic        ce_in,
  input wire logic [1:0]  cpl_in,
  // feature register access
  input wire logic        msr_wr_in,
  input wire logic        msr_rd_in,
  input wire logic [31:0] msr_index_in,
  input wire logic [63:0] msr_wdata_in,
  input wire logic        msr_done_out,
  input wire logic        msr_gp_out,
  input wire logic [63:0] extended_feature_enable_out,
  // flag events and results
  input wire logic        flags_wr_in,
  input wire logic        task_sw_in,
  input wire logic        task_sw_nest_in,
  input wire logic        interrupt_return_in,
  input wire logic        exc_in,
  input wire logic        exc_ibp_in,
  input wire logic        io_instr_in,
  input wire logic        ibp_hit_in,
  input wire logic [63:0] flags_out,
  input wire logic [63:0] stacked_flags_out,
  input wire logic        interrupt_return_task_sw_out,
  input wire logic        ibp_db_out,
  input wire logic        gp_fault_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================
  // register access
  wire logic acc = ce_in && (msr_wr_in || msr_rd_in);
  wire logic hit = msr_index_in == sffe_pkg::SFFE_EXTENDED_FEATURE_ENABLE_INDEX;
  wire logic must_be_zero = (msr_wdata_in & sffe_pkg::SFFE_EXTENDED_FEATURE_ENABLE_MBZ) != 64'h0;
  acc_done_a: assert property (acc && hit |=> msr_done_out)
    else $error("feature access not answered");
  other_idx_a: assert property (acc && !hit
    |=> !msr_done_out && !msr_gp_out)
    else $error("foreign index answered");
  rd_priv_a: assert property (ce_in && msr_rd_in && hit
    && cpl_in != 2'h0 |=> msr_gp_out)
    else $error("unprivileged read not refused");
  mbz_keep_a: assert property (ce_in && msr_wr_in && hit && must_be_zero
    |=> msr_gp_out && $stable(extended_feature_enable_out))
    else $error("must be zero write accepted");
  zero_bits_a: assert property (extended_feature_enable_out[7:1] == 7'h0
    && extended_feature_enable_out[63:16] == 48'h0)
    else $error("reserved feature bits nonzero");
  // ==========================================
  // flags
  pop_vm_a: assert property (ce_in && flags_wr_in && !task_sw_in
    && !interrupt_return_in |=> $stable(flags_out[17]))
    else $error("pop changed emulation mode");
  nest_set_a: assert property (ce_in && task_sw_in && task_sw_nest_in
    |=> flags_out[14])
    else $error("nested flag not set");
  interrupt_return_sw_a: assert property (ce_in && interrupt_return_in && !task_sw_in
    |=> interrupt_return_task_sw_out
    == ($past(flags_out[14]) && !$past(extended_feature_enable_out[10])))
    else $error("return task switch wrong");
  stack_rf_a: assert property (ce_in && exc_in
    |=> stacked_flags_out[16] == !$past(exc_ibp_in))
    else $error("stacked resume bit wrong");
  ibp_sup_a: assert property (ce_in && ibp_hit_in
    |=> ibp_db_out == !$past(flags_out[16]))
    else $error("breakpoint suppression wrong");
  io_gp_a: assert property (ce_in && io_instr_in
    && cpl_in > flags_out[13:12] |=> gp_fault_out)
    else $error("io level fault missing");
endmodule

bind sffe_top sffe_props u_props (.mclk_in, .rst_n_in, .ce_in, .cpl_in,
  .msr_wr_in, .msr_rd_in, .msr_index_in, .msr_wdata_in, .msr_done_out,
  .msr_gp_out, .extended_feature_enable_out, .flags_wr_in, .task_sw_in, .task_sw_nest_in,
  .interrupt_return_in, .exc_in, .exc_ibp_in, .io_instr_in, .ibp_hit_in, .flags_out,
  .stacked_flags_out, .interrupt_return_task_sw_out, .ibp_db_out, .gp_fault_out);

/* bench/tb_system_flags_feature_enable.sv */
module tb_system_flags_feature_enable;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // event vector codes
  localparam logic [9:0] TSW = 10'h200, IRT = 10'h100, POP = 10'h080;
  localparam logic [9:0] RET = 10'h040, EXC = 10'h020, SET = 10'h010;
  localparam logic [9:0] CLR = 10'h008, IOI = 10'h004, UNA = 10'h002;
  localparam logic [9:0] IBP = 10'h001;
  localparam logic [31:0] IDX = sffe_pkg::SFFE_EXTENDED_FEATURE_ENABLE_INDEX;
  logic        mclk_in, rst_n_in, msr_wr_in, msr_rd_in, ok, a, ce, pg;
  logic [31:0] ix;
  logic [63:0] wd, fd, extended_feature_enable_m, d, e, rdata, extended_feature_enable, flg, stk;
  logic [9:0]  pl;
  logic [7:0]  md;
  logic [1:0]  c;
  logic        done, gp, admit, vact, itsw, dbx, gpf, acf;
  int          n_fail, tests_run, i;
  int          cyc = 0;
  sffe_top u_dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce),
    .cpl_in(md[7:6]), .align_mask_in(md[5]), .emu_ext_in(md[4]),
    .prot_vint_in(md[3]), .task_sw_nest_in(md[2]),
    .task_sw_gate_in(md[1]), .exc_ibp_in(md[0]), .paging_in(pg),
    .msr_wr_in(msr_wr_in), .msr_rd_in(msr_rd_in), .msr_index_in(ix),
    .msr_wdata_in(wd), .msr_rdata_out(rdata), .msr_done_out(done),
    .msr_gp_out(gp), .extended_feature_enable_out(extended_feature_enable), .flags_wr_in(pl[7]),
    .flags_wdata_in(fd), .retire_in(pl[6]), .task_sw_in(pl[9]),
    .task_sw_flags_in(fd), .interrupt_return_in(pl[8]), .interrupt_return_flags_in(fd),
    .exc_in(pl[5]), .int_en_set_in(pl[4]), .int_en_clr_in(pl[3]),
    .io_instr_in(pl[2]), .mem_unaligned_in(pl[1]), .ibp_hit_in(pl[0]),
    .flags_out(flg), .stacked_flags_out(stk), .int_admit_out(admit),
    .vif_active_out(vact), .interrupt_return_task_sw_out(itsw), .ibp_db_out(dbx),
    .gp_fault_out(gpf), .ac_fault_out(acf));
  // ==========================================
  // clock and hang guard
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  // a hang counts as a mismatch
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      give_verdict();
    end
  end
  // ==========================================
  // shared tasks
  task automatic give_verdict();
    if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [63:0] ex, logic [63:0] got);
    tests_run++;
    if (got !== ex) begin
      n_fail++;
      $display("Error %s expected %h got %h", nm, ex, got);
    end
  endtask
  // one event pulse, then results settle one edge later
  task automatic ev(logic [9:0] p, logic [63:0] v, logic [7:0] m);
    @(posedge mclk_in);
    pl <= p;
    fd <= v;
    md <= m;
    @(posedge mclk_in);
    pl <= 10'h0;
    #1;
  endtask
  task automatic msr(logic w, logic [31:0] x, logic [63:0] v, logic [1:0] p);
    @(posedge mclk_in);
    msr_wr_in <= w;
    msr_rd_in <= !w;
    ix <= x;
    wd <= v;
    md <= {p, 6'h0};
    @(posedge mclk_in);
    msr_wr_in <= 1'b0;
    msr_rd_in <= 1'b0;
    #1;
  endtask
  // pop keeps emulation mode, bit 1 reads one
  function automatic logic [63:0] popx(logic [63:0] v, logic [63:0] o);
    return {42'h0, (v[21:0] & sffe_pkg::SFFE_FLAGS_WMASK & ~22'h20000)
      | (o[21:0] & 22'h20000) | 22'h2};
  endfunction
  // ==========================================
  // main sequence
  initial begin
    {pl, md, fd, ix, wd, msr_wr_in, msr_rd_in, pg} = '0;
    {n_fail, tests_run} = '0;
    ce = 1'b1;
    extended_feature_enable_m = 64'h0;
    rst_n_in = 1'b0;
    repeat (8) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    #1;
    void'($urandom(32'he5f4));
    chk("flags_rst", 64'h2, flg);
    chk("extended_feature_enable_rst", 64'h0, extended_feature_enable);
    // random writes, half with reserved bits clear, each read back
    for (i = 0; i < 24; i++) begin
      d = {$urandom, $urandom};
      if (i[0]) d = d & 64'hf9ff;
      c = (i % 3 == 0) ? 2'($urandom_range(3)) : 2'h0;
      ok = c == 2'h0 && (d & 64'hffff_ffff_ffff_0600) == 64'h0;
      msr(1'b1, IDX, d, c);
      chk("wr_done", 64'h1, done);
      chk("wr_gp", !ok, gp);
      if (ok) extended_feature_enable_m = d & sffe_pkg::SFFE_EXTENDED_FEATURE_ENABLE_RWM;
      chk("extended_feature_enable", extended_feature_enable_m, extended_feature_enable);
      msr(1'b0, IDX, 64'h0, c);
      chk("rd_gp", c != 2'h0, gp);
      if (c == 2'h0) chk("rdata", extended_feature_enable_m, rdata);
    end
    msr(1'b1, IDX + 32'h1, 64'h1, 2'h0);
    chk("foreign", 64'h0, {done, gp});
    // random pops, io and unaligned accesses at random levels
    e = 64'h2;
    for (i = 0; i < 16; i++) begin
      d = {$urandom, $urandom};
      c = 2'($urandom_range(3));
      a = 1'($urandom_range(1));
      e = popx(d, e);
      ev(POP, d, 8'h0);
      chk("pop", e, flg);
      chk("admit", e[9], admit);
      ev(IOI, 64'h0, {c, 6'h0});
      chk("io_gp", c > e[13:12], gpf);
      ev(UNA, 64'h0, {c, a, 5'h0});
      chk("ac", a && e[18] && c == 2'h3, acf);
    end
    // nested task switch, then nested return
    ev(TSW, 64'h20000, 8'h04);
    chk("nest", 64'h24002, flg);
    ev(POP, 64'h0, 8'h0);
    chk("vm_keep", 64'h20002, flg);
    ev(TSW, 64'h0, 8'h04);
    ev(IRT, 64'h0, 8'h0);
    chk("interrupt_return_sw", 64'h1, itsw);
    ev(POP, 64'h0, 8'h0);
    ev(IRT, 64'h10000, 8'h0);
    chk("interrupt_return_plain", 64'h0, itsw);
    chk("rf_load", 64'h10002, flg);
    // resume flag survives one retire, then clears
    ev(IBP, 64'h0, 8'h0);
    chk("ibp_sup", 64'h0, dbx);
    ev(RET, 64'h0, 8'h0);
    chk("rf_defer", 64'h1, flg[16]);
    ev(RET, 64'h0, 8'h0);
    chk("rf_clear", 64'h0, flg[16]);
    ev(IBP, 64'h0, 8'h0);
    chk("ibp_db", 64'h1, dbx);
    ev(EXC, 64'h0, 8'h00);
    chk("stk_rf", 64'h10002, stk);
    ev(EXC, 64'h0, 8'h01);
    chk("stk_rf_bp", 64'h2, stk);
    // virtual interrupt with pending set, then cleared
    ev(POP, 64'h100000, 8'h10);
    ev(SET, 64'h0, 8'h10);
    chk("vif_act", 64'h1, vact);
    chk("vip_gp", 64'h1, gpf);
    chk("vip_keep", 64'h100002, flg);
    ev(POP, 64'h0, 8'h10);
    ev(SET, 64'h0, 8'h10);
    chk("vif_set", 64'h80002, flg);
    ev(CLR, 64'h0, 8'h10);
    chk("vif_clr", 64'h2, flg);
    ev(POP, 64'h3000, 8'h10);
    ev(IOI, 64'h0, 8'h10);
    chk("vif_off", 64'h0, vact);
    // level 3 io field: set and clear reach the real enable bit
    ev(SET, 64'h0, 8'h10);
    chk("ie_set", 64'h1, admit);
    chk("ie_flags", 64'h3202, flg);
    ev(CLR, 64'h0, 8'h10);
    chk("ie_clr", 64'h0, admit);
    // long mode: enable bit, then paging makes the active bit
    ev(POP, 64'h0, 8'h0);
    msr(1'b1, IDX, 64'h100, 2'h0);
    chk("lme_wr", 64'h100, extended_feature_enable);
    @(posedge mclk_in);
    pg <= 1'b1;
    msr(1'b0, IDX, 64'h0, 2'h0);
    chk("lma_rd", 64'h500, rdata);
    msr(1'b1, IDX, 64'h100, 2'h0);
    chk("lma_gp", 64'h1, gp);
    chk("lma_keep", 64'h500, extended_feature_enable);
    ev(TSW, 64'h0, 8'h04);
    ev(IRT, 64'h0, 8'h0);
    chk("interrupt_return_long", 64'h0, itsw);
    ev(POP, 64'h0, 8'h10);
    chk("vif_long", 64'h0, vact);
    ev(POP, 64'h0, 8'h08);
    chk("vif_pvi", 64'h1, vact);
    // low clock enable freezes every flag
    @(posedge mclk_in);
    ce <= 1'b0;
    ev(POP, 64'h3fffff, 8'h0);
    chk("ce_hold", 64'h2, flg);
    @(posedge mclk_in);
    ce <= 1'b1;
    give_verdict();
  end
endmodule
